// ### fsp_map.vh
// Register map, key values and field positions of the flash self-program block
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define FSP_ADDR_KEY 8'h00
`define FSP_ADDR_MODE 8'h04
`define FSP_ADDR_STATUS 8'h08
`define FSP_ADDR_CMD 8'h0C
`define FSP_ADDR_PTR_HI 8'h10
`define FSP_ADDR_PTR_LO 8'h14
`define FSP_ADDR_CMP_HI 8'h18
`define FSP_ADDR_CMP_LO 8'h1C
`define FSP_ADDR_PROT 8'h20
`define FSP_ADDR_BUSY 8'h24

// ---------------------------------------------------------------------------
// Values
// ---------------------------------------------------------------------------
`define FSP_PROTECT_KEY 8'hA5
`define FSP_MODE_SELF 8'h01
`define FSP_MODE_NORMAL 8'h00
`define FSP_CMD_ERASE 8'h03
`define FSP_LOW_FIXED 8'h00
`define FSP_RST_BYTE 8'h00

// ---------------------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------------------
`define FSP_ST_SEQERR 0
`define FSP_ST_VERIFY 1
`define FSP_ST_PROTECT 2
`define FSP_ST_W 3

`endif

// ### fsp_keyseq.v
// Protected key sequence that switches between normal and self-program mode
`timescale 1ns/1ps
`include "fsp_map.vh"

module fsp_keyseq (
  input wire clk_sys,
  input wire nrst,
  input wire key_wr,
  input wire mode_wr,
  input wire other_wr,
  input wire [7:0] wdata,
  output reg self_mode_r,
  output reg seq_err_r
);

  // ---------------------------------------------------------------------------
  // Sequence states
  // ---------------------------------------------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_KEYED = 4'b0010;
  localparam S_FIRST = 4'b0100;
  localparam S_SECOND = 4'b1000;

  reg [3:0] state_r;
  reg [7:0] val_r;

  // Key, value, complement, value; any other write breaks the chain
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      val_r <= `FSP_RST_BYTE;
      self_mode_r <= 1'b0;
      seq_err_r <= 1'b0;
    end else begin
      seq_err_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (key_wr && wdata == `FSP_PROTECT_KEY) begin
            state_r <= S_KEYED;
          end else if (key_wr || mode_wr) begin
            seq_err_r <= 1'b1;
          end
        end
        S_KEYED: begin
          if (mode_wr) begin
            val_r <= wdata;
            state_r <= S_FIRST;
          end else if (key_wr || other_wr) begin
            seq_err_r <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_FIRST: begin
          if (mode_wr && wdata == ~val_r) begin
            state_r <= S_SECOND;
          end else if (mode_wr || key_wr || other_wr) begin
            seq_err_r <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_SECOND: begin
          if (mode_wr && wdata == val_r &&
              (val_r == `FSP_MODE_SELF || val_r == `FSP_MODE_NORMAL)) begin
            self_mode_r <= val_r[0];
            state_r <= S_IDLE;
          end else if (mode_wr || key_wr || other_wr) begin
            seq_err_r <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ### fsp_core.v
// Flash self-program control: APB registers, mode key sequence, block erase
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fsp_map.vh"

module fsp_core #(
  parameter BLK_W = 8,
  parameter [7:0] PROT_RST = 8'h00
) (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire halt_exec,
  output reg cpu_hold,
  output reg cpu_resume,
  output reg erase_req,
  output reg [BLK_W-1:0] erase_block,
  input wire erase_done,
  input wire erase_fail,
  output wire self_mode
);

  // ---------------------------------------------------------------------------
  // Erase sequencer states
  // ---------------------------------------------------------------------------
  localparam E_IDLE = 3'b001;
  localparam E_RUN = 3'b010;
  localparam E_DONE = 3'b100;

  reg [2:0] est_r;
  reg [2:0] est_nxt;
  reg [7:0] cmd_r;
  reg [BLK_W-1:0] ptr_hi_r;
  reg [7:0] ptr_lo_r;
  reg [BLK_W-1:0] cmp_hi_r;
  reg [7:0] cmp_lo_r;
  reg [BLK_W-1:0] prot_r;
  reg [`FSP_ST_W-1:0] status_r;
  reg [`FSP_ST_W-1:0] status_set;
  reg [31:0] rdata_nxt;
  reg hit;
  reg req_nxt;
  reg resume_nxt;
  wire [7:0] addr;
  wire wr_en;
  wire key_wr;
  wire mode_wr;
  wire other_wr;
  wire seq_err;
  wire params_ok;
  wire blk_protected;

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------

  // Every access completes in its first access cycle
  assign addr = paddr[7:0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;

  // Address decode
  always @* begin
    hit = 1'b0;
    case (addr)
      `FSP_ADDR_KEY, `FSP_ADDR_MODE, `FSP_ADDR_STATUS, `FSP_ADDR_CMD,
      `FSP_ADDR_PTR_HI, `FSP_ADDR_PTR_LO, `FSP_ADDR_CMP_HI, `FSP_ADDR_CMP_LO,
      `FSP_ADDR_PROT, `FSP_ADDR_BUSY: begin
        hit = (paddr[31:8] == 24'h00_0000);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Write strobes toward the key sequence
  assign key_wr = wr_en & (addr == `FSP_ADDR_KEY);
  assign mode_wr = wr_en & (addr == `FSP_ADDR_MODE);
  assign other_wr = wr_en & ~key_wr & ~mode_wr;

  // Read mux; key register reads as zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (addr)
      `FSP_ADDR_MODE: begin
        rdata_nxt[0] = self_mode;
      end
      `FSP_ADDR_STATUS: begin
        rdata_nxt[`FSP_ST_W-1:0] = status_r;
      end
      `FSP_ADDR_CMD: begin
        rdata_nxt[7:0] = cmd_r;
      end
      `FSP_ADDR_PTR_HI: begin
        rdata_nxt[BLK_W-1:0] = ptr_hi_r;
      end
      `FSP_ADDR_PTR_LO: begin
        rdata_nxt[7:0] = ptr_lo_r;
      end
      `FSP_ADDR_CMP_HI: begin
        rdata_nxt[BLK_W-1:0] = cmp_hi_r;
      end
      `FSP_ADDR_CMP_LO: begin
        rdata_nxt[7:0] = cmp_lo_r;
      end
      `FSP_ADDR_PROT: begin
        rdata_nxt[BLK_W-1:0] = prot_r;
      end
      `FSP_ADDR_BUSY: begin
        rdata_nxt[0] = cpu_hold;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the setup cycle, held through the access
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Command and address registers
  // ---------------------------------------------------------------------------

  // Plain read/write registers loaded by software
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_r <= `FSP_RST_BYTE;
      ptr_hi_r <= {BLK_W{1'b0}};
      ptr_lo_r <= `FSP_RST_BYTE;
      cmp_hi_r <= {BLK_W{1'b0}};
      cmp_lo_r <= `FSP_RST_BYTE;
      prot_r <= PROT_RST[BLK_W-1:0];
    end else if (wr_en) begin
      case (addr)
        `FSP_ADDR_CMD: begin
          cmd_r <= pwdata[7:0];
        end
        `FSP_ADDR_PTR_HI: begin
          ptr_hi_r <= pwdata[BLK_W-1:0];
        end
        `FSP_ADDR_PTR_LO: begin
          ptr_lo_r <= pwdata[7:0];
        end
        `FSP_ADDR_CMP_HI: begin
          cmp_hi_r <= pwdata[BLK_W-1:0];
        end
        `FSP_ADDR_CMP_LO: begin
          cmp_lo_r <= pwdata[7:0];
        end
        `FSP_ADDR_PROT: begin
          prot_r <= pwdata[BLK_W-1:0];
        end
        default: begin
          cmd_r <= cmd_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Mode key sequence
  // ---------------------------------------------------------------------------
  fsp_keyseq u_keyseq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .key_wr(key_wr),
    .mode_wr(mode_wr),
    .other_wr(other_wr),
    .wdata(pwdata[7:0]),
    .self_mode_r(self_mode),
    .seq_err_r(seq_err)
  );

  // ---------------------------------------------------------------------------
  // Block erase sequencer
  // ---------------------------------------------------------------------------

  // Pointer and compare must name one whole block
  assign params_ok = (ptr_lo_r == `FSP_LOW_FIXED) && (cmp_lo_r == `FSP_LOW_FIXED) &&
                     (cmp_hi_r == ptr_hi_r);
  // Blocks below the boundary are locked
  assign blk_protected = (ptr_hi_r < prot_r);

  // Next state, flash request and core release
  always @* begin
    est_nxt = est_r;
    req_nxt = 1'b0;
    resume_nxt = 1'b0;
    status_set = {`FSP_ST_W{1'b0}};
    status_set[`FSP_ST_SEQERR] = seq_err;
    case (est_r)
      E_IDLE: begin
        if (halt_exec && self_mode) begin
          if (cmd_r != `FSP_CMD_ERASE) begin
            est_nxt = E_DONE;
          end else if (blk_protected || !params_ok) begin
            status_set[`FSP_ST_PROTECT] = 1'b1;
            est_nxt = E_DONE;
          end else begin
            req_nxt = 1'b1;
            est_nxt = E_RUN;
          end
        end
      end
      E_RUN: begin
        if (erase_done) begin
          status_set[`FSP_ST_VERIFY] = erase_fail;
          est_nxt = E_DONE;
        end
      end
      E_DONE: begin
        resume_nxt = 1'b1;
        est_nxt = E_IDLE;
      end
      default: begin
        est_nxt = E_IDLE;
      end
    endcase
  end

  // Sequencer registers; the core stays held until release
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      est_r <= E_IDLE;
      erase_req <= 1'b0;
      erase_block <= {BLK_W{1'b0}};
      cpu_hold <= 1'b0;
      cpu_resume <= 1'b0;
    end else begin
      est_r <= est_nxt;
      erase_req <= req_nxt;
      cpu_resume <= resume_nxt;
      cpu_hold <= (est_nxt != E_IDLE);
      if (req_nxt) begin
        erase_block <= ptr_hi_r;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------------------

  // Writing 0 to a bit clears it; a new event in that cycle wins
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_r <= {`FSP_ST_W{1'b0}};
    end else if (wr_en && addr == `FSP_ADDR_STATUS) begin
      status_r <= (status_r & pwdata[`FSP_ST_W-1:0]) | status_set;
    end else begin
      status_r <= status_r | status_set;
    end
  end

endmodule

// ### fsp_core_monitor.sv
// Assertion checker on the ports of the flash self-program core
`timescale 1ns/1ps
`include "fsp_map.vh"
module fsp_mon (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire halt_exec,
  input wire cpu_hold,
  input wire cpu_resume,
  input wire erase_req,
  input wire erase_done,
  input wire self_mode
);
  // ---------------
  // Port properties
  // ---------------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Mode only moves on a mode control write, to the written value
  a_mode_cause: assert property (
    $changed(self_mode) |-> $past(psel && penable && pwrite && paddr == `FSP_ADDR_MODE))
    else $error("mode changed without mode write");
  a_mode_value: assert property (
    $changed(self_mode) |-> self_mode == $past(pwdata[0]))
    else $error("mode differs from written value");
  // Halt handling
  a_halt_normal: assert property (
    halt_exec && !self_mode && !cpu_hold |=> !cpu_hold && !erase_req)
    else $error("halt in normal mode started a command");
  a_req_cause: assert property (
    erase_req |-> cpu_hold && $past(halt_exec) && $past(self_mode))
    else $error("erase request without halt in self mode");
  a_done_resume: assert property (
    erase_done && cpu_hold |-> ##2 cpu_resume)
    else $error("no resume two cycles after erase done");
  a_resume_end: assert property (
    cpu_resume |-> !cpu_hold && $past(cpu_hold) ##1 !cpu_resume)
    else $error("resume pulse malformed");
  a_hold_bound: assert property (
    $rose(cpu_hold) |-> ##[1:40] cpu_resume)
    else $error("core held too long");
  // Bus error response
  a_unmapped_err: assert property (
    psel && penable && paddr[31:8] != 24'h00_0000 |-> pslverr)
    else $error("no error for unmapped address");
  a_err_phase: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule
bind fsp_core fsp_mon i_mon (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .halt_exec(halt_exec),
  .cpu_hold(cpu_hold), .cpu_resume(cpu_resume), .erase_req(erase_req), .erase_done(erase_done),
  .self_mode(self_mode));

// ### flash_self_program_mode_erase_tb.sv
// Self-checking bench for the flash self-program core
`timescale 1ns/1ps
`include "fsp_map.vh"
module flash_self_program_mode_erase_tb;
  // ---------------
  // Signals and DUT
  // ---------------
  logic clk_sys, nrst, psel, penable, pwrite, halt_exec, erase_done, erase_fail, fail_v;
  logic [31:0] paddr, pwdata;
  wire [31:0] prdata;
  wire [7:0] erase_block;
  wire pready, pslverr, cpu_hold, cpu_resume, erase_req, self_mode;
  int n_fail, num_checks, cyc, seed, k, i, n_req, req0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0] exp_blk, blk;
  logic [31:0] bad [4];
  fsp_core i_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .cpu_hold(cpu_hold), .cpu_resume(cpu_resume), .erase_req(erase_req),
    .erase_block(erase_block), .erase_done(erase_done), .erase_fail(erase_fail), .self_mode(self_mode));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ---------------
  // Tasks
  // ---------------
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, expected answer noted in the queue
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] ex);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({!w, ex});
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000, {1'b0, ex});
  endtask
  // Key byte then three mode bytes
  task keys(input logic [31:0] s);
    wr(`FSP_ADDR_KEY, {24'h00_0000, s[31:24]});
    for (k = 2; k >= 0; k--)
      wr(`FSP_ADDR_MODE, {24'h00_0000, s[k*8+:8]});
  endtask
  task halt;
    @(posedge clk_sys);
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
  endtask
  task erase(input logic [7:0] cmd, input logic [7:0] b, input logic [7:0] ch, input logic fl,
    input logic rq, input logic [31:0] st);
    wr(`FSP_ADDR_CMD, {24'h00_0000, cmd});
    wr(`FSP_ADDR_PTR_HI, {24'h00_0000, b});
    wr(`FSP_ADDR_PTR_LO, 32'h0000_0000);
    wr(`FSP_ADDR_CMP_HI, {24'h00_0000, ch});
    wr(`FSP_ADDR_CMP_LO, 32'h0000_0000);
    exp_blk = b;
    fail_v = fl;
    req0 = n_req;
    halt;
    k = 0;
    while (cpu_resume !== 1'b1 && k < 50) begin
      @(negedge clk_sys);
      k++;
    end
    chk("cpu_resume", 32'h0000_0001, {31'h0, cpu_resume});
    chk("erase_req", {31'h0, rq}, n_req - req0);
    rd(`FSP_ADDR_STATUS, st);
  endtask
  // ---------------
  // Processes
  // ---------------
  // Result watcher takes the oldest note at the edge that completes each access
  always @(posedge clk_sys) begin
    if (nrst && psel && penable && pready) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33])
        chk("prdata", e[31:0], prdata);
    end
  end
  // Flash array stand-in, random latency; request looked at mid-cycle where it is settled
  initial begin
    erase_done = 1'b0;
    erase_fail = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (erase_req === 1'b1) begin
        n_req++;
        chk("erase_block", {24'h00_0000, exp_blk}, {24'h00_0000, erase_block});
        repeat (1 + (8'($random(seed)) & 8'h03)) @(posedge clk_sys);
        erase_done <= 1'b1;
        erase_fail <= fail_v;
        @(posedge clk_sys);
        erase_done <= 1'b0;
        erase_fail <= 1'b0;
      end
    end
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim;
    end
  end
  // Main sequence
  initial begin
    seed = 63;
    {psel, penable, pwrite, halt_exec, fail_v} = 5'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    exp_blk = 8'h00;
    nrst = 1'b0;
    bad = '{32'h5A01_FE01, 32'hA501_FD01, 32'hA502_FD02, 32'hA501_FE00};
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`FSP_ADDR_STATUS, 32'h0000_0000);
    rd(`FSP_ADDR_MODE, 32'h0000_0000);
    apb(1'b0, 32'h0000_0100, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, 32'h0000_0040, 32'h0000_00FF, 33'h1_0000_0000);
    $display("test reset done");
    halt;
    repeat (3) @(negedge clk_sys);
    chk("cpu_hold", 32'h0000_0000, {31'h0, cpu_hold});
    $display("test normal halt done");
    for (i = 0; i < 4; i++) begin
      wr(`FSP_ADDR_STATUS, 32'h0000_0000);
      keys(bad[i]);
      rd(`FSP_ADDR_STATUS, 32'h0000_0001);
      rd(`FSP_ADDR_MODE, 32'h0000_0000);
    end
    $display("test broken keys done");
    wr(`FSP_ADDR_STATUS, 32'h0000_0000);
    keys(32'hA501_FE00);
    rd(`FSP_ADDR_MODE, 32'h0000_0000);
    wr(`FSP_ADDR_MODE, 32'h0000_0001);
    rd(`FSP_ADDR_MODE, 32'h0000_0000);
    rd(`FSP_ADDR_STATUS, 32'h0000_0001);
    wr(`FSP_ADDR_STATUS, 32'h0000_0000);
    keys(32'hA501_FE01);
    rd(`FSP_ADDR_STATUS, 32'h0000_0000);
    rd(`FSP_ADDR_MODE, 32'h0000_0001);
    chk("self_mode", 32'h0000_0001, {31'h0, self_mode});
    $display("test enter done");
    wr(`FSP_ADDR_PROT, 32'h0000_0010);
    for (i = 0; i < 4; i++) begin
      blk = 8'h10 + (8'($random(seed)) & 8'h3F);
      wr(`FSP_ADDR_STATUS, 32'h0000_0000);
      erase(`FSP_CMD_ERASE, blk, blk, i[0], 1'b1, {30'h0, i[0], 1'b0});
    end
    erase(`FSP_CMD_ERASE, blk, blk, 1'b0, 1'b1, 32'h0000_0002);
    wr(`FSP_ADDR_STATUS, 32'h0000_0000);
    blk = 8'($random(seed)) & 8'h0F;
    erase(`FSP_CMD_ERASE, blk, blk, 1'b0, 1'b0, 32'h0000_0004);
    wr(`FSP_ADDR_STATUS, 32'h0000_0000);
    erase(`FSP_CMD_ERASE, 8'h40, 8'h41, 1'b0, 1'b0, 32'h0000_0004);
    wr(`FSP_ADDR_STATUS, 32'h0000_0000);
    erase(8'h05, 8'h40, 8'h40, 1'b0, 1'b0, 32'h0000_0000);
    $display("test erase done");
    wr(`FSP_ADDR_STATUS, 32'h0000_0000);
    keys(32'hA500_FF00);
    rd(`FSP_ADDR_MODE, 32'h0000_0000);
    rd(`FSP_ADDR_STATUS, 32'h0000_0000);
    $display("test leave done");
    end_sim;
  end
endmodule
